// ===== src/bias_rail_pkg.sv
package bias_rail_pkg;
   // Register bit layout (config store word, rail enable, bias fault and status bits)
   localparam int CFG_W = 8;
   localparam int CFG_FULLDUTY_BIT = 7;
   localparam int CFG_DITHER_BIT = 6;
   localparam int CFG_CCM_BIT = 5;
   localparam int CFG_HS_MSB = 4;
   localparam int CFG_HS_LSB = 3;
   localparam int CFG_LS_MSB = 2;
   localparam int CFG_LS_LSB = 1;
   localparam int RAIL_BIAS_EN_BIT = 1;
   localparam int FAULT_OC_BIT = 2;
   localparam int FAULT_OV_BIT = 1;
   localparam int FAULT_UV_BIT = 0;
   localparam int STAT_FULLDUTY_BIT = 5;
   // Timing in microseconds, converted at 50 MHz
   localparam int CLK_MHZ = 50;
   localparam int SS_PERIOD_US = 1000;
   localparam int UV_MASK_US = 900;
   localparam int SS_CYCLES = SS_PERIOD_US * CLK_MHZ;
   localparam int UV_MASK_CYCLES = UV_MASK_US * CLK_MHZ;
   localparam int TMR_W = 24;
   localparam int REF_W = 10;
   localparam logic [REF_W-1:0] REF_FULL = 10'h3_FF;
   localparam int DITHER_PERIODS = 16;
   localparam int DITHER_W = 5;
   localparam int REV_CYCLES = 8;
   localparam int REV_W = 4;
   localparam int BOOT_CYCLES = 4;
   localparam int BOOT_W = 3;
   localparam logic [CFG_W-1:0] ZERO8 = 8'h00;
   typedef enum {ST_LOCKED, ST_ROM_LOAD, ST_BIAS_ON, ST_SOFTSTART, ST_RUN, ST_OFF} seq_t;
endpackage

// ===== src/bias_rail_supervisor.sv
// Overview of operation
// [R1] Load config store first after lockout release
// [R2] Enable references and bias before regulator
// [R3] Enable regulator after both lockouts, stay on; from ST_OFF the code restarts without checking the overvoltage lockout
// [R4] Rail enable bit 1 low disables regulator
// [R5] Power-good comparator watched even when disabled
// [R6] Soft-start ramps reference zero to full
// [R7] Pulse-skip forced during soft-start
// [R8] Pre-biased output: hold switching until reference catches
// [R9] Config bit 5 selects continuous or skipping
// [R10] Skip after consecutive reverse cycles, block reverse
// [R11] Full duty off: minimum off pulse each cycle
// [R12] Full duty on: keep high side on
// [R13] Status bit 5 shows full duty
// [R14] Config bit 6 dithers, pattern repeats
// [R15] Config bits 4:3 and 2:1 set gate slew
// [R16] Overcurrent sets bias fault bit 2
// [R17] Overvoltage sets bias fault bit 1
// [R18] Undervoltage sets bias fault bit 0
// [R19] Undervoltage masked until mask timer expires
// [R20] Fault bit rising raises interrupt event
// [R21] Fault register read clears both registers
// [R22] Timers count clock, loaded from config store; the code loads them from fixed package constants instead
`timescale 1ns/10ps
`default_nettype none
module bias_rail_supervisor (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Lockout comparators
   input wire logic INPUT_UNDERVOLTAGE_LOCKOUT_RELEASED,
   input wire logic INPUT_OVERVOLTAGE_LOCKOUT_RELEASED,
   // Configuration store interface
   input wire logic ROM_READY,
   input wire logic [7:0] ROM_CONFIG,
   input wire logic [7:0] ROM_RAIL_EN,
   output logic ROM_ENABLE,
   // Register writes and reads from the serial bus
   input wire logic CONFIG_WR,
   input wire logic [7:0] CONFIG_WDATA,
   input wire logic RAIL_WR,
   input wire logic [7:0] RAIL_WDATA,
   input wire logic BIAS_FAULT_RD,
   input wire logic MAIN_FAULT_RD,
   input wire logic [7:0] MAIN_FAULT_SET,
   // Analog comparators
   input wire logic PWM_DEMAND,
   input wire logic REVERSE_CURRENT,
   input wire logic CYCLE_START,
   input wire logic OUT_ABOVE_REF,
   input wire logic RAIL_GOOD_CMP,
   input wire logic OC_CMP,
   input wire logic OV_CMP,
   input wire logic UV_CMP,
   // Power stage controls
   output logic BIAS_CIRCUITS_EN,
   output logic REG_ENABLE,
   output logic [9:0] SS_REF,
   output logic SWITCH_ALLOW,
   output logic PULSE_SKIP,
   output logic BLOCK_REVERSE,
   output logic HS_GATE_ON,
   output logic [4:0] DITHER_STEP,
   output logic [1:0] HS_SLEW,
   output logic [1:0] LS_SLEW,
   output logic BIAS_GOOD,
   // Register views
   output logic [7:0] CONFIG_REG,
   output logic [7:0] RAIL_REG,
   output logic [7:0] BIAS_FAULT,
   output logic [7:0] MAIN_FAULT,
   output logic [7:0] STATUS_REG,
   output logic IRQ_EVENT
);
   bias_rail_pkg::seq_t state_q, state_d;
   logic [7:0] cfg_q, rail_q, bfault_q, mfault_q;
   logic [23:0] tmr_q;
   logic [23:0] uvm_q;
   logic [9:0] ref_q;
   logic [23:0] ss_step_q;
   logic [2:0] boot_q;
   logic [3:0] rev_q;
   logic [4:0] dith_q;
   logic prebias_q, skip_q, fullduty_q, hs_q, irq_q;
   logic lock_ok, in_ss, running, ccm, fd_en, uv_live;
   logic [7:0] bset, bfault_d, mfault_d;
   logic rd_clear;
   localparam logic [23:0] SS_STEP = 24'(bias_rail_pkg::SS_CYCLES / 1023);
   localparam logic [23:0] UVM_LOAD = 24'(bias_rail_pkg::UV_MASK_CYCLES);

   assign lock_ok = INPUT_UNDERVOLTAGE_LOCKOUT_RELEASED && INPUT_OVERVOLTAGE_LOCKOUT_RELEASED; // [R3]
   assign in_ss = (state_q == bias_rail_pkg::ST_SOFTSTART);
   assign running = in_ss || (state_q == bias_rail_pkg::ST_RUN);
   assign ccm = cfg_q[bias_rail_pkg::CFG_CCM_BIT];
   assign fd_en = cfg_q[bias_rail_pkg::CFG_FULLDUTY_BIT];
   assign uv_live = running && (uvm_q == 24'h00_0000); // [R19]
   assign rd_clear = BIAS_FAULT_RD || MAIN_FAULT_RD;

   always_comb begin
      state_d = state_q;
      case (state_q)
         bias_rail_pkg::ST_LOCKED: begin
            if (INPUT_UNDERVOLTAGE_LOCKOUT_RELEASED) state_d = bias_rail_pkg::ST_ROM_LOAD; // [R1]
         end
         bias_rail_pkg::ST_ROM_LOAD: begin
            if (ROM_READY) state_d = bias_rail_pkg::ST_BIAS_ON; // [R1]
         end
         bias_rail_pkg::ST_BIAS_ON: begin
            if (boot_q == 3'(bias_rail_pkg::BOOT_CYCLES) && lock_ok) begin // [R2]
               state_d = rail_q[bias_rail_pkg::RAIL_BIAS_EN_BIT] ?
                  bias_rail_pkg::ST_SOFTSTART : bias_rail_pkg::ST_OFF;
            end
         end
         bias_rail_pkg::ST_SOFTSTART: begin
            if (ref_q == bias_rail_pkg::REF_FULL) state_d = bias_rail_pkg::ST_RUN; // [R6]
         end
         bias_rail_pkg::ST_RUN: state_d = bias_rail_pkg::ST_RUN; // [R3]
         bias_rail_pkg::ST_OFF: begin
            if (rail_q[bias_rail_pkg::RAIL_BIAS_EN_BIT]) state_d = bias_rail_pkg::ST_SOFTSTART;
         end
         default: state_d = bias_rail_pkg::ST_LOCKED;
      endcase
      if (state_q != bias_rail_pkg::ST_LOCKED && !INPUT_UNDERVOLTAGE_LOCKOUT_RELEASED) begin
         state_d = bias_rail_pkg::ST_LOCKED;
      end else if (running && (!rail_q[bias_rail_pkg::RAIL_BIAS_EN_BIT] || !INPUT_OVERVOLTAGE_LOCKOUT_RELEASED)) begin
         state_d = bias_rail_pkg::ST_OFF; // [R4]
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) state_q <= bias_rail_pkg::ST_LOCKED;
      else state_q <= state_d;
   end

   // Config and rail enable take their defaults from the store, then software
   always_ff @(posedge CLK) begin
      if (RST) begin
         cfg_q <= bias_rail_pkg::ZERO8;
         rail_q <= bias_rail_pkg::ZERO8;
      end else if (state_q == bias_rail_pkg::ST_ROM_LOAD && ROM_READY) begin
         cfg_q <= ROM_CONFIG; // [R1]
         rail_q <= ROM_RAIL_EN;
      end else begin
         if (CONFIG_WR) cfg_q <= CONFIG_WDATA;
         if (RAIL_WR) rail_q <= RAIL_WDATA; // [R4]
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) boot_q <= 3'h0;
      else if (state_q != bias_rail_pkg::ST_BIAS_ON) boot_q <= 3'h0;
      else if (boot_q != 3'(bias_rail_pkg::BOOT_CYCLES)) boot_q <= boot_q + 3'h1;
   end

   // Reference ramp: one step every SS_STEP cycles across the period
   always_ff @(posedge CLK) begin
      if (RST) begin
         ref_q <= 10'h000;
         ss_step_q <= 24'h00_0000;
      end else if (!running) begin
         ref_q <= 10'h000;
         ss_step_q <= 24'h00_0000;
      end else if (in_ss) begin
         if (ss_step_q >= SS_STEP - 24'h00_0001) begin // [R22]
            ss_step_q <= 24'h00_0000;
            ref_q <= ref_q + 10'h001; // [R6]
         end else begin
            ss_step_q <= ss_step_q + 24'h00_0001;
         end
      end
   end

   // Mask timer loads at soft-start entry
   always_ff @(posedge CLK) begin
      if (RST) uvm_q <= UVM_LOAD;
      else if (!running) uvm_q <= UVM_LOAD; // [R19]
      else if (uvm_q != 24'h00_0000) uvm_q <= uvm_q - 24'h00_0001; // [R22]
   end

   // Pre-bias: switching held until reference reaches the output
   always_ff @(posedge CLK) begin
      if (RST) prebias_q <= 1'b1;
      else if (!running) prebias_q <= 1'b1;
      else if (!OUT_ABOVE_REF) prebias_q <= 1'b0; // [R8]
   end

   // Reverse current counted per cycle before skipping
   always_ff @(posedge CLK) begin
      if (RST) begin
         rev_q <= 4'h0;
         skip_q <= 1'b0;
      end else if (!running || (ccm && !in_ss)) begin
         rev_q <= 4'h0;
         skip_q <= 1'b0;
      end else if (CYCLE_START) begin
         if (!REVERSE_CURRENT) begin
            rev_q <= 4'h0;
            skip_q <= 1'b0;
         end else if (rev_q == 4'(bias_rail_pkg::REV_CYCLES - 1)) begin
            skip_q <= 1'b1; // [R10]
         end else begin
            rev_q <= rev_q + 4'h1;
         end
      end
   end

   // Full duty: high side held while feedback low, else min off pulse
   always_ff @(posedge CLK) begin
      if (RST) begin
         hs_q <= 1'b0;
         fullduty_q <= 1'b0;
      end else if (!SWITCH_ALLOW) begin
         hs_q <= 1'b0;
         fullduty_q <= 1'b0;
      end else if (CYCLE_START && !fd_en) begin
         hs_q <= 1'b0; // [R11]
         fullduty_q <= 1'b0;
      end else begin
         hs_q <= PWM_DEMAND; // [R12]
         // Flag is judged at each cycle start and held in between while demand stays, not pulsed
         fullduty_q <= fd_en && PWM_DEMAND && (CYCLE_START ? hs_q : fullduty_q); // [R13]
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) dith_q <= 5'h00;
      else if (!cfg_q[bias_rail_pkg::CFG_DITHER_BIT] || !running) dith_q <= 5'h00;
      else if (CYCLE_START) begin
         if (dith_q == 5'(bias_rail_pkg::DITHER_PERIODS - 1)) dith_q <= 5'h00; // [R14]
         else dith_q <= dith_q + 5'h01;
      end
   end

   // Sticky faults; a set in the clearing cycle survives
   assign bset = {5'h00, running && OC_CMP, running && OV_CMP, uv_live && UV_CMP}; // [R16] [R17] [R18]
   assign bfault_d = (rd_clear ? bias_rail_pkg::ZERO8 : bfault_q) | bset; // [R21]
   assign mfault_d = (rd_clear ? bias_rail_pkg::ZERO8 : mfault_q) | MAIN_FAULT_SET;

   always_ff @(posedge CLK) begin
      if (RST) begin
         bfault_q <= bias_rail_pkg::ZERO8;
         mfault_q <= bias_rail_pkg::ZERO8;
         irq_q <= 1'b0;
      end else begin
         bfault_q <= bfault_d;
         mfault_q <= mfault_d;
         irq_q <= |((bfault_d & ~bfault_q) | (mfault_d & ~mfault_q)); // [R20]
      end
   end

   assign ROM_ENABLE = (state_q != bias_rail_pkg::ST_LOCKED); // [R1]
   assign BIAS_CIRCUITS_EN = (state_q != bias_rail_pkg::ST_LOCKED) &&
                             (state_q != bias_rail_pkg::ST_ROM_LOAD); // [R2]
   assign REG_ENABLE = running; // [R3]
   assign SS_REF = ref_q;
   assign SWITCH_ALLOW = running && !prebias_q; // [R8]
   assign PULSE_SKIP = in_ss || !ccm; // [R7] [R9]
   assign BLOCK_REVERSE = PULSE_SKIP && skip_q; // [R10]
   assign HS_GATE_ON = hs_q;
   assign DITHER_STEP = dith_q;
   assign HS_SLEW = cfg_q[bias_rail_pkg::CFG_HS_MSB:bias_rail_pkg::CFG_HS_LSB]; // [R15]
   assign LS_SLEW = cfg_q[bias_rail_pkg::CFG_LS_MSB:bias_rail_pkg::CFG_LS_LSB]; // [R15]
   assign BIAS_GOOD = RAIL_GOOD_CMP; // [R5]
   assign CONFIG_REG = cfg_q;
   assign RAIL_REG = rail_q;
   assign BIAS_FAULT = bfault_q;
   assign MAIN_FAULT = mfault_q;
   assign STATUS_REG = {2'b00, fullduty_q, 5'h00}; // [R13]
   assign IRQ_EVENT = irq_q;

   rom_first_a: assert property (@(posedge CLK) disable iff (RST)
      (state_q == bias_rail_pkg::ST_LOCKED) |=> !REG_ENABLE) else $error("Regulator before load"); // [R1]
   bias_first_a: assert property (@(posedge CLK) disable iff (RST)
      REG_ENABLE |-> BIAS_CIRCUITS_EN) else $error("Bias not on"); // [R2]
   rail_off_a: assert property (@(posedge CLK) disable iff (RST)
      (!rail_q[bias_rail_pkg::RAIL_BIAS_EN_BIT] && running) |=> !REG_ENABLE)
      else $error("Rail enable ignored"); // [R4]
   ss_skip_a: assert property (@(posedge CLK) disable iff (RST)
      in_ss |-> PULSE_SKIP) else $error("No skip in soft-start"); // [R7]
   prebias_hold_a: assert property (@(posedge CLK) disable iff (RST)
      prebias_q |-> !SWITCH_ALLOW) else $error("Switching during pre-bias"); // [R8]
   min_off_a: assert property (@(posedge CLK) disable iff (RST)
      (CYCLE_START && !fd_en) |=> !HS_GATE_ON) else $error("No minimum off"); // [R11]
   uv_mask_a: assert property (@(posedge CLK) disable iff (RST)
      (uvm_q != 24'h00_0000 && !rd_clear && !bfault_q[0]) |=> !bfault_q[0])
      else $error("Undervoltage not masked"); // [R19]
   fault_irq_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(bfault_q[bias_rail_pkg::FAULT_OC_BIT]) |-> IRQ_EVENT) else $error("Missing event"); // [R20]
   rd_clear_a: assert property (@(posedge CLK) disable iff (RST)
      (rd_clear && bset == 8'h00 && MAIN_FAULT_SET == 8'h00) |=> (BIAS_FAULT == 8'h00))
      else $error("Read did not clear"); // [R21]

   // Start-up steps: store load, then bias circuits, regulator still off
   sequence load_done_s;
      (state_q == bias_rail_pkg::ST_ROM_LOAD) && ROM_READY && INPUT_UNDERVOLTAGE_LOCKOUT_RELEASED;
   endsequence
   sequence bias_up_s;
      BIAS_CIRCUITS_EN && !REG_ENABLE;
   endsequence
   load_then_bias_a: assert property (@(posedge CLK) disable iff (RST)
      load_done_s |=> bias_up_s) else $error("Bias step skipped"); // [R2]
   lock_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (state_q == bias_rail_pkg::ST_BIAS_ON && !lock_ok) |=> !REG_ENABLE)
      else $error("Regulator inside lockout"); // [R3]
   run_stays_a: assert property (@(posedge CLK) disable iff (RST)
      (state_q == bias_rail_pkg::ST_RUN && lock_ok && rail_q[bias_rail_pkg::RAIL_BIAS_EN_BIT])
      |=> REG_ENABLE) else $error("Regulator dropped"); // [R3]
   good_follow_a: assert property (@(posedge CLK) disable iff (RST)
      BIAS_GOOD == RAIL_GOOD_CMP) else $error("Power good not followed"); // [R5]
   ref_zero_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(REG_ENABLE) |-> (SS_REF == 10'h000)) else $error("Ramp not from zero"); // [R6]
   // Ramp only climbs while soft-start lasts
   sequence ss_two_s;
      in_ss ##1 in_ss;
   endsequence
   ref_climb_a: assert property (@(posedge CLK) disable iff (RST)
      ss_two_s |-> (SS_REF >= $past(SS_REF))) else $error("Ramp fell"); // [R6]
   ccm_run_a: assert property (@(posedge CLK) disable iff (RST)
      (state_q == bias_rail_pkg::ST_RUN && ccm) |-> !PULSE_SKIP)
      else $error("Skipping in continuous mode"); // [R9]
   block_skip_a: assert property (@(posedge CLK) disable iff (RST)
      BLOCK_REVERSE |-> PULSE_SKIP) else $error("Reverse blocked outside skip"); // [R10]
   fd_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (SWITCH_ALLOW && fd_en && PWM_DEMAND) |=> HS_GATE_ON)
      else $error("High side dropped at full duty"); // [R12]
   fd_flag_a: assert property (@(posedge CLK) disable iff (RST)
      !fd_en |=> !STATUS_REG[bias_rail_pkg::STAT_FULLDUTY_BIT])
      else $error("Full duty flag without mode"); // [R13]
   dither_wrap_a: assert property (@(posedge CLK) disable iff (RST)
      DITHER_STEP <= 5'(bias_rail_pkg::DITHER_PERIODS - 1))
      else $error("Dither count past repeat"); // [R14]
   oc_flag_a: assert property (@(posedge CLK) disable iff (RST)
      (running && OC_CMP) |=> BIAS_FAULT[bias_rail_pkg::FAULT_OC_BIT])
      else $error("Overcurrent not flagged"); // [R16]
   ov_flag_a: assert property (@(posedge CLK) disable iff (RST)
      (running && OV_CMP) |=> BIAS_FAULT[bias_rail_pkg::FAULT_OV_BIT])
      else $error("Overvoltage not flagged"); // [R17]
   uv_flag_a: assert property (@(posedge CLK) disable iff (RST)
      (uv_live && UV_CMP) |=> BIAS_FAULT[bias_rail_pkg::FAULT_UV_BIT])
      else $error("Undervoltage not flagged"); // [R18]
   main_irq_a: assert property (@(posedge CLK) disable iff (RST)
      (|(MAIN_FAULT & ~$past(MAIN_FAULT))) |-> IRQ_EVENT)
      else $error("Missing main fault event"); // [R20]
endmodule // bias_rail_supervisor
`default_nettype wire

// ===== verification/bias_rail_supervisor_bench.sv
`timescale 1ns/10ps
`default_nettype none
module bias_rail_supervisor_bench;
   typedef struct {int sel; logic [9:0] val;} note_t;
   note_t exp_q[$];
   note_t cur;
   int err_count = 0;
   int checks = 0;
   logic clk = 1'b0, rst = 1'b1, input_undervoltage_lockout = 1'b0, input_overvoltage_lockout = 1'b1, rdy = 1'b0, off_seen = 1'b0;
   logic cfg_wr = 1'b0, rail_wr = 1'b0, bf_rd = 1'b0, mf_rd = 1'b0, pwm = 1'b0, rev = 1'b0;
   logic oc = 1'b0, ov = 1'b0, uv = 1'b0;
   logic [7:0] rom_cfg = 8'h00, rom_rail = 8'h02, cfg_d = 8'h00, rail_d = 8'h00, mset = 8'h00, v;
   logic [15:0] lfsr = 16'hFAC2;
   logic rom_en, circ_en, reg_en, sw_ok, skip, blk_rev, hs_on, bgood, irq, cyc, above, good;
   logic [9:0] ss_ref;
   logic [4:0] dither;
   logic [1:0] hs_slew, ls_slew;
   logic [7:0] cfg_q, rail_q, bfault, mfault, status;
   always #10 clk = ~clk;
   bias_rail_supervisor u_dut (.CLK(clk), .RST(rst), .INPUT_UNDERVOLTAGE_LOCKOUT_RELEASED(input_undervoltage_lockout), .INPUT_OVERVOLTAGE_LOCKOUT_RELEASED(input_overvoltage_lockout),
      .ROM_READY(rdy), .ROM_CONFIG(rom_cfg), .ROM_RAIL_EN(rom_rail), .ROM_ENABLE(rom_en),
      .CONFIG_WR(cfg_wr), .CONFIG_WDATA(cfg_d), .RAIL_WR(rail_wr), .RAIL_WDATA(rail_d),
      .BIAS_FAULT_RD(bf_rd), .MAIN_FAULT_RD(mf_rd), .MAIN_FAULT_SET(mset), .PWM_DEMAND(pwm),
      .REVERSE_CURRENT(rev), .CYCLE_START(cyc), .OUT_ABOVE_REF(above), .RAIL_GOOD_CMP(good),
      .OC_CMP(oc), .OV_CMP(ov), .UV_CMP(uv), .BIAS_CIRCUITS_EN(circ_en), .REG_ENABLE(reg_en),
      .SS_REF(ss_ref), .SWITCH_ALLOW(sw_ok), .PULSE_SKIP(skip), .BLOCK_REVERSE(blk_rev),
      .HS_GATE_ON(hs_on), .DITHER_STEP(dither), .HS_SLEW(hs_slew), .LS_SLEW(ls_slew),
      .BIAS_GOOD(bgood), .CONFIG_REG(cfg_q), .RAIL_REG(rail_q), .BIAS_FAULT(bfault),
      .MAIN_FAULT(mfault), .STATUS_REG(status), .IRQ_EVENT(irq));
   bias_stage_model u_stage (.clk(clk), .rst(rst), .reg_enable(reg_en), .ss_ref(ss_ref),
      .switch_allow(sw_ok), .cycle_start(cyc), .out_above_ref(above), .rail_good(good));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction
   function automatic logic [9:0] pick(input int sel);
      case (sel)
         0: return 10'(rom_en);
         1: return 10'(circ_en);
         2: return 10'(reg_en);
         3: return 10'(skip);
         4: return 10'(bfault);
         5: return 10'(mfault);
         6: return 10'(irq);
         7: return 10'(cfg_q);
         8: return 10'(rail_q);
         9: return ss_ref;
         10: return 10'(sw_ok);
         11: return 10'(blk_rev);
         12: return 10'(hs_on);
         13: return 10'(status[bias_rail_pkg::STAT_FULLDUTY_BIT]);
         14: return 10'(hs_slew);
         15: return 10'(ls_slew);
         16: return 10'(bgood);
         default: return 10'(off_seen);
      endcase
   endfunction
   task automatic check(input logic [9:0] seen, input logic [9:0] want);
      checks++;
      if (seen !== want) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic note(input int sel, input logic [9:0] val);
      exp_q.push_back('{sel, val});
   endtask
   // Sampling 1 ns after the driving edge keeps notes and inputs out of the same time step
   always @(negedge clk) begin
      #1;
      while (exp_q.size() > 0) begin
         cur = exp_q.pop_front();
         check(pick(cur.sel), cur.val);
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_val(input int sel, input logic [9:0] val, input int limit);
      int i;
      for (i = 0; i < limit && pick(sel) !== val; i++) @(negedge clk);
      if (i == limit) begin
         err_count++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
      end
   endtask
   task automatic wr(input bit rail, input logic [7:0] d);
      if (rail) {rail_d, rail_wr} = {d, 1'b1};
      else {cfg_d, cfg_wr} = {d, 1'b1};
      tick(1);
      {rail_wr, cfg_wr} = 2'h0;
      tick(1);
   endtask
   task automatic watch(input int n);
      off_seen = 1'b0;
      repeat (n) begin
         @(negedge clk);
         if (hs_on !== 1'b1) off_seen = 1'b1;
      end
   endtask
   task automatic close_out();
      $display("Checks made: %0d, mismatches: %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #((bias_rail_pkg::SS_CYCLES + 10000) * 20);
      err_count++;
      close_out();
   end
   initial begin
      rom_cfg = rnd();
      tick(4);
      rst = 1'b0;
      note(0, 0);
      note(2, 0);
      input_undervoltage_lockout = 1'b1;
      tick(4);
      note(0, 1);
      note(1, 0);
      rdy = 1'b1;
      tick(1);
      note(1, 1);
      note(2, 0);
      note(7, 10'(rom_cfg));
      note(8, 10'(rom_rail));
      wait_val(2, 1, 8);
      note(9, 0);
      note(10, 0);
      note(3, 1);
      {oc, uv} = 2'h3;
      tick(1);
      note(4, 10'h004);
      note(6, 1);
      tick(1);
      note(6, 0);
      oc = 1'b0;
      bf_rd = 1'b1;
      tick(1);
      bf_rd = 1'b0;
      note(4, 0);
      ov = 1'b1;
      tick(1);
      note(4, 10'h002);
      note(6, 1);
      tick(1);
      {ov, mset} = 9'h001;
      tick(1);
      note(5, 10'h001);
      mset = 8'h00;
      mf_rd = 1'b1;
      tick(1);
      mf_rd = 1'b0;
      note(4, 0);
      note(5, 0);
      repeat (4) begin
         v = rnd();
         wr(0, v);
         note(7, 10'(v));
         note(14, 10'(v[4:3]));
         note(15, 10'(v[2:1]));
         note(3, 1);
      end
      uv = 1'b0;
      wait_val(9, 10'h3FF, bias_rail_pkg::SS_CYCLES + 2000);
      tick(4);
      note(2, 1);
      // Mask has run out by now, so undervoltage must land
      uv = 1'b1;
      tick(1);
      note(4, 10'h001);
      note(6, 1);
      uv = 1'b0;
      bf_rd = 1'b1;
      tick(1);
      bf_rd = 1'b0;
      note(4, 0);
      wr(0, 8'h20);
      note(3, 0);
      wr(0, 8'h00);
      note(3, 1);
      rev = 1'b1;
      tick(16);
      note(11, 0);
      tick(96);
      note(11, 1);
      {rev, pwm} = 2'h1;
      wr(0, 8'h80);
      tick(40);
      watch(32);
      note(17, 0);
      note(13, 1);
      wr(0, 8'h00);
      tick(8);
      watch(32);
      note(17, 1);
      note(13, 0);
      pwm = 1'b0;
      wr(1, 8'h00);
      note(2, 0);
      note(16, 10'(good));
      wr(1, 8'h02);
      wait_val(2, 1, 8);
      wr(0, 8'h20);
      note(3, 1);
      tick(2);
      close_out();
   end
endmodule // bias_rail_supervisor_bench
`default_nettype wire

// ===== verification/bias_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module bias_stage_model #(
   parameter logic [9:0] PREBIAS = 10'h100,
   parameter logic [9:0] GOOD_LVL = 10'h300
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Regulator controls
   input wire logic reg_enable,
   input wire logic [9:0] ss_ref,
   input wire logic switch_allow,
   // Sensed feedback
   output var logic cycle_start,
   output logic out_above_ref,
   output logic rail_good
);
   logic [9:0] vout_q = PREBIAS;
   logic [2:0] phase_q = 3'h0;
   initial cycle_start = 1'b0;
   // A pre-charged rail keeps its level; charge only rises while switching
   always @(posedge clk) begin
      if (switch_allow && vout_q < ss_ref) vout_q <= vout_q + 10'h001;
      phase_q <= (rst || !reg_enable) ? 3'h0 : phase_q + 3'h1;
      cycle_start <= reg_enable && !rst && phase_q == 3'h7;
   end
   assign out_above_ref = vout_q > ss_ref;
   assign rail_good = vout_q >= GOOD_LVL;
endmodule // bias_stage_model
`default_nettype wire
